/* File: logic/timer16_map.svh */
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH

// ****************************************************************
// Register addresses and reset values
// ****************************************************************
`define TMC_ADDR 16'hFF48
`define BZC_ADDR 16'hFF49
`define PM2_ADDR 16'hFF22
`define TMC_RESET 8'h00
`define BZC_RESET 8'h00
`define PM2_RESET 8'hFF
`define RD_UNMAPPED 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define TMC_LEVEL_BIT 7
`define TMC_OVF_BIT 6
`define TMC_EDGE_HI 5
`define TMC_EDGE_LO 4
`define TMC_INV_BIT 3
`define TMC_CLK_HI 2
`define TMC_CLK_LO 1
`define TMC_OUT_EN_BIT 0
`define BZC_DIV_HI 3
`define BZC_DIV_LO 1
`define BZC_EN_BIT 0
`define BZC_WMASK 8'h0F
`define PM2_FIXED_MASK 8'h80
`define PM2_FIXED_BIT 7
`define PIN_TIMER_BIT 6
`define PIN_BUZZ_BIT 1

// ****************************************************************
// Counts
// ****************************************************************
`define PRESC_MASK_DIV4 7'h03
`define PRESC_MASK_DIV64 7'h3F
`define PRESC_MASK_DIV128 7'h7F
`define PRESC_RESET 7'h00
`define CNT_RESET 16'h0000
`define CNT_MAX 16'hFFFF
`define CNT_STEP 16'h0001
`define BUZZ_EXP_0 4'h4
`define BUZZ_EXP_1 4'h5
`define BUZZ_EXP_2 4'h8
`define BUZZ_EXP_3 4'h9
`define BUZZ_EXP_4 4'hA
`define BUZZ_EXP_5 4'hB
`define BUZZ_EXP_6 4'hC
`define BUZZ_EXP_7 4'hD
`define BUZZ_CNT_RESET 13'h0000

`endif

/* File: logic/timer16_pkg.sv */
package timer16_pkg;

  typedef enum logic [1:0] {
    CLK_DIV4 = 2'b00,
    CLK_DIV64 = 2'b01,
    CLK_DIV128 = 2'b10,
    CLK_SUB = 2'b11
  } clk_sel_type;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_type;

  typedef struct packed {
    logic [7:0] tmc;
    logic [7:0] bzc;
    logic [7:0] dir;
    logic [15:0] counter;
    logic [15:0] capture;
    logic [6:0] presc;
    logic sub_prev;
    logic cap_prev;
    logic [7:0] pin_data;
    logic [7:0] rd_data;
    logic irq;
  } timer_state_type;

  typedef struct packed {
    logic [12:0] count;
    logic wave;
  } buzz_state_type;

endpackage : timer16_pkg

/* File: logic/buzz_divider.sv */
`timescale 1ns/10ps
`include "timer16_map.svh"
module buzz_divider #(
  parameter int CNT_WIDTH = 13
) (
  input wire logic clk_in,            // System clock
  input wire logic rst_n_in,          // Async reset, active low
  input wire logic ce_in,             // Clock enable
  input wire logic tick_in,           // Count clock pulse
  input wire logic [2:0] div_sel_in,  // Buzzer divider code
  input wire logic enable_in,         // Buzzer output enable
  output logic wave_out               // Square wave
);
  import timer16_pkg::*;

  buzz_state_type s_r;
  buzz_state_type s_nxt;
  logic [3:0] exp_sel;

  // ****************************************************************
  // Divider code to exponent
  // ****************************************************************
  function automatic logic [3:0] buzz_exp(input logic [2:0] code);
    unique case (code)
      3'h0: buzz_exp = `BUZZ_EXP_0;
      3'h1: buzz_exp = `BUZZ_EXP_1;
      3'h2: buzz_exp = `BUZZ_EXP_2;
      3'h3: buzz_exp = `BUZZ_EXP_3;
      3'h4: buzz_exp = `BUZZ_EXP_4;
      3'h5: buzz_exp = `BUZZ_EXP_5;
      3'h6: buzz_exp = `BUZZ_EXP_6;
      3'h7: buzz_exp = `BUZZ_EXP_7;
    endcase
  endfunction : buzz_exp

  // Wave is bit exp-1 of the tick count: half period high, half low
  always_comb begin
    s_nxt = s_r;
    exp_sel = buzz_exp(div_sel_in);
    if (!enable_in) begin
      s_nxt.count = `BUZZ_CNT_RESET;
      s_nxt.wave = 1'b0;
    end else if (tick_in) begin
      s_nxt.count = CNT_WIDTH'(s_r.count + 1'b1);
      s_nxt.wave = s_nxt.count[exp_sel - 4'h1];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  assign wave_out = s_r.wave;

  a_buzz_wave_src: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    ce_in && enable_in && tick_in |=> wave_out == s_r.count[$past(exp_sel) - 4'h1])
    else $error("buzzer wave not taken from divider bit");

endmodule : buzz_divider

/* File: logic/timer16_control_regs.sv */
`timescale 1ns/10ps
`include "timer16_map.svh"
module timer16_control_regs (
  input wire logic clk_in,                        // System clock
  input wire logic rst_n_in,                      // Async reset, active low
  input wire logic ce_in,                         // Clock enable
  input wire logic [15:0] addr_in,                // CPU address
  input wire logic wr_in,                         // Write strobe
  input wire logic bit_op_in,                     // 1: single-bit write
  input wire logic [2:0] bit_sel_in,              // Bit for bit write
  input wire logic [7:0] wr_data_in,              // Write data
  input wire logic rd_in,                         // Read strobe
  output logic [7:0] rd_data_out,                 // Read data
  input wire logic sub_clk_in,                    // Subsystem clock level
  input wire logic capture_in,                    // Capture input pin
  input wire logic [15:0] compare_value_in,       // Compare value
  input wire logic [7:0] port2_latch_in,          // Port output latch
  output logic compare_irq_out,                   // Compare match pulse
  output logic [15:0] counter_out,                // Up counter
  output logic counter_valid_out,                 // Counter readable
  output logic [15:0] capture_hold_out,           // Captured count
  output logic [7:0] port2_data_out,              // Pin output data
  output logic [7:0] port2_oe_out                 // Pin output enables
);
  import timer16_pkg::*;

  timer_state_type s_r;
  timer_state_type s_nxt;
  clk_sel_type clk_sel;
  logic tick;
  logic wrap;
  logic match;
  logic unsync;
  logic cap_rise;
  logic cap_fall;
  logic cap_event;
  logic buzz_wave;
  logic [7:0] tmc_new;
  logic ovf_kept;
  logic out_level;

  // ****************************************************************
  // Bit or byte write merge
  // ****************************************************************
  function automatic logic [7:0] merge_write(input logic [7:0] old,
                                             input logic [7:0] data,
                                             input logic bit_op,
                                             input logic [2:0] sel);
    merge_write = old;
    if (bit_op) begin
      merge_write[sel] = data[0];
    end else begin
      merge_write = data;
    end
  endfunction : merge_write

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    clk_sel = clk_sel_type'(s_r.tmc[`TMC_CLK_HI:`TMC_CLK_LO]);
    s_nxt.presc = 7'(s_r.presc + 1'b1);
    s_nxt.sub_prev = sub_clk_in;
    s_nxt.cap_prev = capture_in;
    unique case (clk_sel)
      CLK_DIV4: tick = (s_r.presc & `PRESC_MASK_DIV4) == `PRESC_MASK_DIV4;
      CLK_DIV64: tick = (s_r.presc & `PRESC_MASK_DIV64) == `PRESC_MASK_DIV64;
      CLK_DIV128: tick =
        (s_r.presc & `PRESC_MASK_DIV128) == `PRESC_MASK_DIV128;
      CLK_SUB: tick = sub_clk_in & ~s_r.sub_prev;
    endcase
    wrap = tick && (s_r.counter == `CNT_MAX);
    match = tick && (s_r.counter == compare_value_in);
    // Counter free runs and keeps counting through a match
    if (tick) begin
      s_nxt.counter = 16'(s_r.counter + `CNT_STEP);
    end
    s_nxt.irq = match;
    // Subclock feeding buzzer is not resynchronised
    unsync = (clk_sel == CLK_SUB) && s_r.bzc[`BZC_EN_BIT];
    cap_rise = capture_in & ~s_r.cap_prev;
    cap_fall = ~capture_in & s_r.cap_prev;
    cap_event = !unsync &&
      ((cap_rise && s_r.tmc[`TMC_EDGE_LO]) ||
       (cap_fall && s_r.tmc[`TMC_EDGE_HI]));
    if (cap_event) begin
      s_nxt.capture = s_r.counter;
    end
    // Mode register
    tmc_new = s_r.tmc;
    ovf_kept = s_r.tmc[`TMC_OVF_BIT];
    if (wr_in && addr_in == `TMC_ADDR) begin
      tmc_new = merge_write(s_r.tmc, wr_data_in, bit_op_in, bit_sel_in);
      ovf_kept = s_r.tmc[`TMC_OVF_BIT] & tmc_new[`TMC_OVF_BIT];
    end
    s_nxt.tmc[`TMC_EDGE_HI:`TMC_OUT_EN_BIT] =
      tmc_new[`TMC_EDGE_HI:`TMC_OUT_EN_BIT];
    s_nxt.tmc[`TMC_OVF_BIT] = ovf_kept | wrap;
    // Output level held low while disabled, so it starts low
    if (!s_r.tmc[`TMC_OUT_EN_BIT]) begin
      out_level = 1'b0;
    end else if (match && s_r.tmc[`TMC_INV_BIT]) begin
      out_level = ~s_r.tmc[`TMC_LEVEL_BIT];
    end else begin
      out_level = s_r.tmc[`TMC_LEVEL_BIT];
    end
    s_nxt.tmc[`TMC_LEVEL_BIT] = out_level;
    // Buzzer register, upper bits read as zero
    if (wr_in && addr_in == `BZC_ADDR) begin
      s_nxt.bzc = merge_write(s_r.bzc, wr_data_in, bit_op_in, bit_sel_in)
        & `BZC_WMASK;
    end
    // Direction register, top bit fixed
    if (wr_in && addr_in == `PM2_ADDR) begin
      s_nxt.dir = merge_write(s_r.dir, wr_data_in, bit_op_in, bit_sel_in)
        | `PM2_FIXED_MASK;
    end
    // Pin data: alternate functions override the port latch
    s_nxt.pin_data = port2_latch_in;
    if (s_r.tmc[`TMC_OUT_EN_BIT]) begin
      s_nxt.pin_data[`PIN_TIMER_BIT] = s_r.tmc[`TMC_LEVEL_BIT];
    end
    if (s_r.bzc[`BZC_EN_BIT]) begin
      s_nxt.pin_data[`PIN_BUZZ_BIT] = buzz_wave;
    end
    if (rd_in) begin
      unique case (addr_in)
        `TMC_ADDR: s_nxt.rd_data = s_r.tmc;
        `BZC_ADDR: s_nxt.rd_data = s_r.bzc;
        `PM2_ADDR: s_nxt.rd_data = s_r.dir;
        default: s_nxt.rd_data = `RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '{tmc: `TMC_RESET, bzc: `BZC_RESET, dir: `PM2_RESET,
               counter: `CNT_RESET, capture: `CNT_RESET,
               presc: `PRESC_RESET, sub_prev: 1'b0, cap_prev: 1'b0,
               pin_data: `RD_UNMAPPED, rd_data: `RD_UNMAPPED,
               irq: 1'b0};
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Buzzer divider
  // ****************************************************************
  buzz_divider #(
    .CNT_WIDTH(13)
  ) u_buzz (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .tick_in(tick),
    .div_sel_in(s_r.bzc[`BZC_DIV_HI:`BZC_DIV_LO]),
    .enable_in(s_r.bzc[`BZC_EN_BIT]),
    .wave_out(buzz_wave)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rd_data_out = s_r.rd_data;
  assign compare_irq_out = s_r.irq;
  assign counter_out = s_r.counter;
  assign counter_valid_out = !unsync;
  assign capture_hold_out = s_r.capture;
  assign port2_data_out = s_r.pin_data;
  assign port2_oe_out = ~s_r.dir;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_overflow_sets_flag: assert property (
    ce_in && wrap |=> s_r.tmc[`TMC_OVF_BIT] && s_r.counter == `CNT_RESET)
    else $error("overflow did not set flag and wrap");

  a_flag_clear_write: assert property (
    ce_in && !wrap && wr_in && !bit_op_in && addr_in == `TMC_ADDR &&
    !wr_data_in[`TMC_OVF_BIT] |=> !s_r.tmc[`TMC_OVF_BIT])
    else $error("write of zero did not clear overflow flag");

  a_counter_steps: assert property (
    ce_in && tick && !wrap |=> s_r.counter == 16'($past(s_r.counter) + 1'b1))
    else $error("counter did not step by one");

  a_counter_holds: assert property (
    ce_in && !tick |=> $stable(s_r.counter))
    else $error("counter moved without a tick");

  a_match_irq: assert property (
    ce_in && match |=> compare_irq_out)
    else $error("compare match did not raise the interrupt");

  a_irq_no_match: assert property (
    ce_in && !match |=> !compare_irq_out)
    else $error("interrupt raised without a compare match");

  a_match_invert: assert property (
    ce_in && match && s_r.tmc[`TMC_INV_BIT] && s_r.tmc[`TMC_OUT_EN_BIT]
    |=> s_r.tmc[`TMC_LEVEL_BIT] != $past(s_r.tmc[`TMC_LEVEL_BIT]))
    else $error("timer output did not invert on match");

  a_level_low_off: assert property (
    ce_in && !s_r.tmc[`TMC_OUT_EN_BIT] |=> !s_r.tmc[`TMC_LEVEL_BIT])
    else $error("timer output level not low while disabled");

  a_capture_latency: assert property (
    ce_in && cap_event |=> capture_hold_out == $past(s_r.counter))
    else $error("capture register missed the count");

  a_capture_blocked: assert property (
    ce_in && unsync |=> $stable(capture_hold_out))
    else $error("capture occurred on unsynchronised subclock");

  a_dir_top_fixed: assert property (
    s_r.dir[`PM2_FIXED_BIT] && !port2_oe_out[`PM2_FIXED_BIT])
    else $error("direction top bit not held at one");

  a_buzz_upper_zero: assert property (
    ce_in && rd_in && addr_in == `BZC_ADDR |=> rd_data_out[7:4] == 4'h0)
    else $error("buzzer register upper bits not zero");

  a_div4_period: assert property (
    ce_in && clk_sel == CLK_DIV4 && tick ##1 ce_in [*3]
    |-> !tick || clk_sel != CLK_DIV4)
    else $error("divide by four tick spacing wrong");

  a_div128_phase: assert property (
    ce_in && clk_sel == CLK_DIV128 && tick |-> s_r.presc == `PRESC_MASK_DIV128)
    else $error("divide by 128 tick off phase");

  a_sub_tick_edge: assert property (
    ce_in && clk_sel == CLK_SUB && tick |-> sub_clk_in && !s_r.sub_prev)
    else $error("subclock tick without a rising edge");

  a_capture_holds: assert property (
    ce_in && !cap_event |=> $stable(capture_hold_out))
    else $error("capture register changed without an edge");

  a_edge_off_none: assert property (
    ce_in && s_r.tmc[`TMC_EDGE_HI:`TMC_EDGE_LO] == EDGE_NONE |-> !cap_event)
    else $error("capture taken while edge select is off");

  a_rise_only: assert property (
    ce_in && s_r.tmc[`TMC_EDGE_HI:`TMC_EDGE_LO] == EDGE_RISE && cap_fall
    |-> !cap_event)
    else $error("falling edge captured in rising mode");

  a_fall_only: assert property (
    ce_in && s_r.tmc[`TMC_EDGE_HI:`TMC_EDGE_LO] == EDGE_FALL && cap_rise
    |-> !cap_event)
    else $error("rising edge captured in falling mode");

  a_timer_pin_data: assert property (
    ce_in && s_r.tmc[`TMC_OUT_EN_BIT]
    |=> port2_data_out[`PIN_TIMER_BIT] == $past(s_r.tmc[`TMC_LEVEL_BIT]))
    else $error("timer pin does not show output level");

  a_port_pin_data: assert property (
    ce_in && !s_r.tmc[`TMC_OUT_EN_BIT]
    |=> port2_data_out[`PIN_TIMER_BIT] ==
        $past(port2_latch_in[`PIN_TIMER_BIT]))
    else $error("timer pin not left to the port latch");

  a_buzz_pin_data: assert property (
    ce_in && s_r.bzc[`BZC_EN_BIT]
    |=> port2_data_out[`PIN_BUZZ_BIT] == $past(buzz_wave))
    else $error("buzzer pin does not show the wave");

  a_level_hold: assert property (
    ce_in && s_r.tmc[`TMC_OUT_EN_BIT] &&
    !(match && s_r.tmc[`TMC_INV_BIT]) |=> $stable(s_r.tmc[`TMC_LEVEL_BIT]))
    else $error("timer output level changed without inversion");

  a_mode_write: assert property (
    ce_in && wr_in && !bit_op_in && addr_in == `TMC_ADDR
    |=> s_r.tmc[`TMC_EDGE_HI:`TMC_OUT_EN_BIT] ==
        $past(wr_data_in[`TMC_EDGE_HI:`TMC_OUT_EN_BIT]))
    else $error("mode register byte write not taken");

  a_dir_write: assert property (
    ce_in && wr_in && !bit_op_in && addr_in == `PM2_ADDR
    |=> s_r.dir[`PM2_FIXED_BIT-1:0] == $past(wr_data_in[`PM2_FIXED_BIT-1:0]))
    else $error("direction register byte write not taken");

  a_read_mode: assert property (
    ce_in && rd_in && addr_in == `TMC_ADDR |=> rd_data_out == $past(s_r.tmc))
    else $error("mode register read returned wrong value");

  a_bzc_upper_reg: assert property (
    s_r.bzc[7:4] == 4'h0)
    else $error("buzzer register upper bits stored");

  c_overflow: cover property (ce_in && wrap);
  c_capture_both: cover property (
    ce_in && cap_event && s_r.tmc[`TMC_EDGE_HI:`TMC_EDGE_LO] == EDGE_BOTH);
  c_match_toggle: cover property (
    ce_in && match && s_r.tmc[`TMC_INV_BIT] && s_r.tmc[`TMC_OUT_EN_BIT]);
  c_buzz_on: cover property (s_r.bzc[`BZC_EN_BIT] && buzz_wave);

endmodule : timer16_control_regs

/* File: bench/timer_pins_model.sv */
`timescale 1ns/10ps
// ****************************************
// Pins around the timer: capture, subclock
// ****************************************
module timer_pins_model (
  input wire logic clk_in,         // System clock
  input wire logic [7:0] data_in,  // Pin output data
  input wire logic [7:0] oe_in,    // Pin output enables
  output logic capture_out,        // Capture pin level
  output logic sub_clk_out,        // Subsystem clock level
  output logic [7:0] level_out     // Resolved pin levels
);
  // Released pins float up to the pull-up level
  always_comb level_out = (data_in & oe_in) | ~oe_in;
  initial begin
    capture_out = 1'b0;
    sub_clk_out = 1'b0;
  end
  task automatic set_capture(input logic v);
    @(posedge clk_in);
    capture_out <= v;
  endtask : set_capture
  // Subclock stands low between wanted ticks
  task automatic sub_tick;
    repeat (2) @(posedge clk_in);
    sub_clk_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    sub_clk_out <= 1'b0;
  endtask : sub_tick
endmodule : timer_pins_model

/* File: bench/timer16_control_regs_tb_top.sv */
`timescale 1ns/10ps
`include "timer16_map.svh"
`define CHK(nm, ex, got) \
  begin \
    total_checks++; \
    if ((got) !== (ex)) begin \
      n_errors++; \
      $display("unexpected %s exp %h got %h", nm, ex, got); \
    end \
  end
module timer16_control_regs_tb_top;
  import timer16_pkg::*;
  logic clk_in, rst_n_in, wr_in, rd_in, bit_op_in, irq, valid;
  logic [2:0] bit_sel_in;
  logic [7:0] wr_data_in, rd_data_out, latch, pdata, poe, d;
  logic [15:0] addr_in, cmp, counter_out, cap, c, n;
  logic sub_clk, capture;
  logic [7:0] lvl;
  int n_errors = 0;
  int total_checks = 0;
  int dv[3] = '{32'h4, 32'h40, 32'h80};
  logic [3:0] ex[8] = '{4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};

  timer16_control_regs DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .ce_in(1'b1), .addr_in(addr_in), .wr_in(wr_in),
    .bit_op_in(bit_op_in), .bit_sel_in(bit_sel_in),
    .wr_data_in(wr_data_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .sub_clk_in(sub_clk), .capture_in(capture),
    .compare_value_in(cmp), .port2_latch_in(latch),
    .compare_irq_out(irq), .counter_out(counter_out),
    .counter_valid_out(valid), .capture_hold_out(cap),
    .port2_data_out(pdata), .port2_oe_out(poe));
  timer_pins_model pins (.clk_in(clk_in), .data_in(pdata), .oe_in(poe),
    .capture_out(capture), .sub_clk_out(sub_clk), .level_out(lvl));

  always #2 clk_in = ~clk_in;

  // ****************************************
  // Bus and timing helpers
  // ****************************************
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask : cyc
  task automatic wr(input logic [15:0] a, input logic [7:0] v,
                    input logic bo, input logic [2:0] s);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= v;
    bit_op_in <= bo;
    bit_sel_in <= s;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 `CHK("read", e, rd_data_out)
  endtask : rchk
  task automatic sync_tick;
    cyc(1);
    c = counter_out;
    for (int i = 0; i < 300 && counter_out === c; i++) cyc(1);
    c = counter_out;
  endtask : sync_tick
  task automatic wait_irq;
    for (int i = 0; i < 100 && irq !== 1'b1; i++) cyc(1);
  endtask : wait_irq
  task automatic close_out;
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    rchk(`TMC_ADDR, 8'h00);
    rchk(`BZC_ADDR, 8'h00);
    rchk(`PM2_ADDR, 8'hFF);
    wr(`BZC_ADDR, 8'hFF, 1'b0, 3'h0);
    rchk(`BZC_ADDR, 8'h0F);
    wr(`BZC_ADDR, 8'h00, 1'b0, 3'h0);
    wr(`PM2_ADDR, 8'h00, 1'b0, 3'h0);
    rchk(`PM2_ADDR, 8'h80);
    `CHK("oe", 8'h7F, poe)
    wr(`PM2_ADDR, 8'hFF, 1'b0, 3'h0);
    wr(`PM2_ADDR, 8'h00, 1'b1, 3'h6);
    rchk(`PM2_ADDR, 8'hBF);
    `CHK("oe", 8'h40, poe)
    `CHK("pin", 8'hFF, lvl)
    wr(`TMC_ADDR, 8'hC0, 1'b0, 3'h0);
    rchk(`TMC_ADDR, 8'h00);
    rchk(16'hFF40, `RD_UNMAPPED);
  endtask : t_regs
  task automatic t_rate;
    for (int s = 0; s < 3; s++) begin
      wr(`TMC_ADDR, {5'h00, 2'(s), 1'b0}, 1'b0, 3'h0);
      sync_tick;
      cyc(dv[s] - 1);
      `CHK("hold", c, counter_out)
      cyc(1);
      `CHK("step", c + 16'h0001, counter_out)
    end
    wr(`TMC_ADDR, 8'h36, 1'b0, 3'h0);
    cyc(1);
    c = counter_out;
    repeat (3) pins.sub_tick;
    cyc(2);
    `CHK("sub", c + 16'h0003, counter_out)
    wr(`BZC_ADDR, 8'h01, 1'b0, 3'h0);
    cyc(1);
    `CHK("valid", 1'b0, valid)
    n = cap;
    pins.set_capture(1'b1);
    pins.set_capture(1'b0);
    cyc(3);
    `CHK("cap", n, cap)
    wr(`BZC_ADDR, 8'h00, 1'b0, 3'h0);
    cyc(1);
    `CHK("valid", 1'b1, valid)
  endtask : t_rate
  task automatic t_capture;
    for (int e = 0; e < 4; e++) begin
      wr(`TMC_ADDR, {2'b00, 2'(e), 4'h4}, 1'b0, 3'h0);
      for (int v = 1; v >= 0; v--) begin
        sync_tick;
        n = cap;
        pins.set_capture(1'(v));
        cyc(3);
        if (v == 1 ? e[0] : e[1]) n = c;
        `CHK("cap", n, cap)
      end
    end
  endtask : t_capture
  task automatic t_compare;
    wr(`TMC_ADDR, 8'h00, 1'b0, 3'h0);
    cyc(2);
    `CHK("port", 1'b1, pdata[6])
    latch <= 8'h00;
    wr(`TMC_ADDR, 8'h09, 1'b0, 3'h0);
    cyc(2);
    `CHK("level", 1'b0, pdata[6])
    for (int k = 0; k < 2; k++) begin
      n = counter_out + 16'h0008;
      @(posedge clk_in);
      cmp <= n;
      wait_irq;
      `CHK("irq", 1'b1, irq)
      `CHK("count", n + 16'h0001, counter_out)
      cyc(1);
      `CHK("irq", 1'b0, irq)
      cyc(1);
      `CHK("level", 1'b1, lvl[6])
      rchk(`TMC_ADDR, k == 0 ? 8'h89 : 8'h81);
      wr(`TMC_ADDR, 8'h01, 1'b0, 3'h0);
    end
  endtask : t_compare
  task automatic t_buzz;
    int k2;
    wr(`PM2_ADDR, 8'h00, 1'b1, 3'h1);
    wr(`TMC_ADDR, 8'h00, 1'b0, 3'h0);
    for (int k = 0; k < 8; k++) begin
      wr(`BZC_ADDR, {4'h0, 3'(k), 1'b1}, 1'b0, 3'h0);
      cyc(1);
      d[0] = pdata[1];
      for (int i = 0; i < 20000 && pdata[1] === d[0]; i++) cyc(1);
      d[0] = pdata[1];
      k2 = 0;
      do begin
        cyc(1);
        k2++;
      end while (pdata[1] === d[0] && k2 < 20000);
      `CHK("half", 32'h1 << (ex[k] + 4'h1), k2)
      wr(`BZC_ADDR, 8'h00, 1'b0, 3'h0);
    end
  endtask : t_buzz

  initial begin
    clk_in = 1'b0;
    rst_n_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    bit_op_in = 1'b0;
    bit_sel_in = 3'h0;
    wr_data_in = 8'h00;
    addr_in = 16'h0000;
    cmp = 16'hFFFF;
    latch = 8'h40;
    @(posedge clk_in);
    #1 `CHK("count", `CNT_RESET, counter_out)
    `CHK("oe", 8'h00, poe)
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs;
    t_rate;
    t_capture;
    t_compare;
    t_buzz;
    close_out;
  end
  initial begin
    repeat (90000) @(posedge clk_in);
    n_errors++;
    close_out;
  end
endmodule : timer16_control_regs_tb_top
